// ---- hdl/cor_pkg.sv ----
// constants, types and opcode patterns for the or and pointer-load slice
// Notes on behaviour
// RQ1: or literal into accumulator, result to accumulator
// RQ2: both ors set negative and zero only
// RQ3: decode or-with-file, read file, or accumulator
// RQ4: target bit 0 accumulator, 1 file
// RQ5: bank bit 0 access bank, 1 bank pointer
// RQ6: one word, one cycle, four quarter phases
// RQ7: pointer load twelve bits, select 0-2, flagless
// RQ8: two words: prefix, select, high; prefix, low
// RQ9: two cycles: high nibble first, low second
// RQ10: skip discards next, one or two nops
package cor_pkg;

	// quarter phases of one instruction cycle, gray order
	typedef enum logic [1:0] {
		Q_DECODE  = 2'b00,
		Q_READ    = 2'b01,
		Q_PROCESS = 2'b11,
		Q_WRITE   = 2'b10
	} cor_phase_t;

	// operations handled by this slice
	typedef enum logic [2:0] {
		OP_NOP      = 3'h0,
		OP_IOR_LIT  = 3'h1,
		OP_IOR_FILE = 3'h2,
		OP_INC_SKZ  = 3'h3,
		OP_INC_SKNZ = 3'h4,
		OP_PTR_HI   = 3'h5,
		OP_PTR_LO   = 3'h6
	} cor_op_t;

	// widths
	localparam int DATA_W    = 8;
	localparam int PTR_W     = 12;
	localparam int BANK_W    = 4;
	localparam int ADDR_W    = 12;
	localparam int PTR_COUNT = 3;
	localparam int SEL_W     = 2;

	// opcode patterns
	localparam logic [7:0] PAT_IOR_LIT   = 8'h09; // 0000 1001
	localparam logic [5:0] PAT_IOR_FILE  = 6'h04; // 0001 00
	localparam logic [5:0] PAT_INC_SKZ   = 6'h0f; // 0011 11
	localparam logic [5:0] PAT_INC_SKNZ  = 6'h12; // 0100 10
	localparam logic [7:0] PAT_PTR_FIRST = 8'hee; // 1110 1110
	localparam logic [1:0] PAT_PTR_ZERO  = 2'h0;  // bits 7:6 of first word
	localparam logic [7:0] PAT_PTR_SECND = 8'hf0; // 1111 0000

	// field positions
	localparam int DEST_BIT = 9;
	localparam int BANK_BIT = 8;
	localparam int SEL_LSB  = 4;

	// reset values and fixed access bank
	localparam logic [DATA_W-1:0] ACC_RST     = 8'h00;
	localparam logic [PTR_W-1:0]  PTR_RST     = 12'h000;
	localparam logic [BANK_W-1:0] ACCESS_BANK = 4'h0;
	localparam logic [SEL_W-1:0]  SEL_INVALID = 2'h3;

endpackage : cor_pkg

// ---- hdl/cor_decode.sv ----
// opcode decoder for the or and pointer-load slice
`timescale 1ns/1ps
`default_nettype none
module cor_decode
(
	// fetched word
	input  wire logic [15:0]          word,
	// decoded fields
	output cor_pkg::cor_op_t          op,
	output wire logic                 dest_file,
	output wire logic                 use_bank,
	output wire logic [7:0]           operand,
	output wire logic [1:0]           ptr_sel,
	output wire logic                 two_word,
	output wire logic                 ptr_second
);

	// pattern matches on the upper bits
	wire logic is_lit   = word[15:8] == cor_pkg::PAT_IOR_LIT;    // RQ1
	wire logic is_file  = word[15:10] == cor_pkg::PAT_IOR_FILE;  // RQ3
	wire logic is_skz   = word[15:10] == cor_pkg::PAT_INC_SKZ;
	wire logic is_sknz  = word[15:10] == cor_pkg::PAT_INC_SKNZ;
	wire logic is_first = (word[15:8] == cor_pkg::PAT_PTR_FIRST)
		&& (word[7:6] == cor_pkg::PAT_PTR_ZERO);                  // RQ8

	// operation select, anything else runs as a no-operation
	assign op = is_lit   ? cor_pkg::OP_IOR_LIT  :
	            is_file  ? cor_pkg::OP_IOR_FILE :
	            is_skz   ? cor_pkg::OP_INC_SKZ  :
	            is_sknz  ? cor_pkg::OP_INC_SKNZ :
	            is_first ? cor_pkg::OP_PTR_HI   : cor_pkg::OP_NOP;

	// fields
	assign dest_file  = word[cor_pkg::DEST_BIT];
	assign use_bank   = word[cor_pkg::BANK_BIT];
	assign operand    = word[7:0];
	assign ptr_sel    = word[cor_pkg::SEL_LSB +: 2];
	assign two_word   = is_first;
	assign ptr_second = word[15:8] == cor_pkg::PAT_PTR_SECND; // RQ8

endmodule : cor_decode
`default_nettype wire

// ---- hdl/cor_exec.sv ----
// execution slice: or ops, indirect pointer load, skip no-operations
`timescale 1ns/1ps
`default_nettype none
module cor_exec
(
	// clock and reset
	input  wire logic                         mclk,
	input  wire logic                         rst,
	// instruction fetch
	input  wire logic [15:0]                  instr_word,
	input  wire logic                         instr_valid,
	// bank pointer from the rest of the core
	input  wire logic [cor_pkg::BANK_W-1:0]   bank_pointer_reg,
	// side access to the file memory
	input  wire logic                         ext_wr_en,
	input  wire logic [cor_pkg::ADDR_W-1:0]   ext_addr,
	input  wire logic [cor_pkg::DATA_W-1:0]   ext_wdata,
	output logic      [cor_pkg::DATA_W-1:0]   ext_rdata,
	// core state
	output logic      [cor_pkg::DATA_W-1:0]   accumulator,
	output logic                              neg_flag,
	output logic                              zero_flag,
	output wire logic [cor_pkg::PTR_COUNT*cor_pkg::PTR_W-1:0] ptr_flat,
	output cor_pkg::cor_phase_t               quarter_phase,
	output logic                              nop_cycle
);

	localparam int MEM_DEPTH = 1 << cor_pkg::ADDR_W;

	// state
	cor_pkg::cor_phase_t            phase_reg;
	cor_pkg::cor_op_t               op_reg;
	logic                           dest_reg;
	logic                           bank_reg;
	logic [7:0]                     opd_reg;
	logic [1:0]                     sel_reg;
	logic                           pend_reg;
	logic                           discard_reg;
	logic                           nop_reg;
	logic [cor_pkg::DATA_W-1:0]     fval_reg;
	logic [cor_pkg::DATA_W-1:0]     result_reg;
	logic [cor_pkg::DATA_W-1:0]     acc_reg;
	logic                           neg_reg;
	logic                           zero_reg;
	logic [cor_pkg::DATA_W-1:0]     erd_reg;
	logic [cor_pkg::PTR_W-1:0]      ptr_reg [cor_pkg::PTR_COUNT];
	logic [cor_pkg::DATA_W-1:0]     mem [MEM_DEPTH];

	// decoder
	cor_pkg::cor_op_t dec_op;
	wire logic        dec_dest;
	wire logic        dec_bank;
	wire logic [7:0]  dec_opd;
	wire logic [1:0]  dec_sel;
	wire logic        dec_two;
	wire logic        dec_second;

	cor_decode u_decode
	(
		.word       (instr_word),
		.op         (dec_op),
		.dest_file  (dec_dest),
		.use_bank   (dec_bank),
		.operand    (dec_opd),
		.ptr_sel    (dec_sel),
		.two_word   (dec_two),
		.ptr_second (dec_second)
	);

	// phase strobes
	wire logic at_decode  = phase_reg == cor_pkg::Q_DECODE;
	wire logic at_read    = phase_reg == cor_pkg::Q_READ;
	wire logic at_process = phase_reg == cor_pkg::Q_PROCESS;
	wire logic at_write   = phase_reg == cor_pkg::Q_WRITE;

	// file address: access bank or bank pointer
	wire logic [cor_pkg::BANK_W-1:0] bank_sel =
		bank_reg ? bank_pointer_reg : cor_pkg::ACCESS_BANK; // RQ5
	wire logic [cor_pkg::ADDR_W-1:0] faddr = {bank_sel, opd_reg};

	// result of the process quarter
	wire logic is_or  = (op_reg == cor_pkg::OP_IOR_LIT)
		|| (op_reg == cor_pkg::OP_IOR_FILE);
	wire logic is_inc = (op_reg == cor_pkg::OP_INC_SKZ)
		|| (op_reg == cor_pkg::OP_INC_SKNZ);
	wire logic [cor_pkg::DATA_W-1:0] or_src =
		(op_reg == cor_pkg::OP_IOR_LIT) ? opd_reg : fval_reg; // RQ1 RQ3
	wire logic [cor_pkg::DATA_W-1:0] result_next =
		is_inc ? cor_pkg::DATA_W'(fval_reg + 8'h01) : (acc_reg | or_src);

	// destination select in the write quarter
	wire logic to_file = at_write && dest_reg
		&& ((op_reg == cor_pkg::OP_IOR_FILE) || is_inc);  // RQ4
	wire logic to_acc  = at_write && ((op_reg == cor_pkg::OP_IOR_LIT)
		|| (!dest_reg && ((op_reg == cor_pkg::OP_IOR_FILE) || is_inc)));
	wire logic skip_hit = at_write
		&& (((op_reg == cor_pkg::OP_INC_SKZ) && (result_reg == 8'h00))
		|| ((op_reg == cor_pkg::OP_INC_SKNZ) && (result_reg != 8'h00)));

	// fetch acceptance at decode
	wire logic take_word  = at_decode && instr_valid;
	wire logic drop_word  = take_word && discard_reg;
	wire logic take_low   = take_word && !discard_reg && pend_reg
		&& dec_second;
	wire logic take_plain = take_word && !discard_reg && !pend_reg;

	// quarter phase sequencer, four clocks per instruction cycle
	always_ff @(posedge mclk)
	begin
		if (rst)
			phase_reg <= cor_pkg::Q_DECODE;
		else
			unique case (phase_reg)
				cor_pkg::Q_DECODE:  phase_reg <= cor_pkg::Q_READ;    // RQ6
				cor_pkg::Q_READ:    phase_reg <= cor_pkg::Q_PROCESS;
				cor_pkg::Q_PROCESS: phase_reg <= cor_pkg::Q_WRITE;
				cor_pkg::Q_WRITE:   phase_reg <= cor_pkg::Q_DECODE;
			endcase
	end

	// decode quarter: latch operation and fields
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			op_reg   <= cor_pkg::OP_NOP;
			dest_reg <= 1'b0;
			bank_reg <= 1'b0;
			opd_reg  <= 8'h00;
		end
		else if (at_decode)
		begin
			op_reg   <= take_low ? cor_pkg::OP_PTR_LO :
			            take_plain ? dec_op : cor_pkg::OP_NOP; // RQ10
			dest_reg <= dec_dest;
			bank_reg <= dec_bank;
			opd_reg  <= dec_opd;
		end
	end

	// two-word pointer load tracking
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			pend_reg <= 1'b0;
			sel_reg  <= 2'h0;
		end
		else if (take_plain && (dec_op == cor_pkg::OP_PTR_HI))
		begin
			pend_reg <= 1'b1; // RQ8
			sel_reg  <= dec_sel;
		end
		else if (take_word && !discard_reg && pend_reg)
			pend_reg <= 1'b0; // wrong second word aborts
	end

	// skip: discard next word, and its second word if two-word
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			discard_reg <= 1'b0;
			nop_reg     <= 1'b0;
		end
		else
		begin
			if (skip_hit)
				discard_reg <= 1'b1; // RQ10
			else if (drop_word)
				discard_reg <= dec_two; // RQ10
			if (at_decode)
				nop_reg <= drop_word;
		end
	end

	// read and process quarters
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			fval_reg   <= 8'h00;
			result_reg <= 8'h00;
		end
		else
		begin
			if (at_read)
				fval_reg <= mem[faddr]; // RQ3
			if (at_process)
				result_reg <= result_next;
		end
	end

	// write quarter: accumulator and flags
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			acc_reg  <= cor_pkg::ACC_RST;
			neg_reg  <= 1'b0;
			zero_reg <= 1'b0;
		end
		else
		begin
			if (to_acc)
				acc_reg <= result_reg; // RQ1 RQ4
			if (at_write && is_or)
			begin
				neg_reg  <= result_reg[7];           // RQ2
				zero_reg <= result_reg == 8'h00;     // RQ2
			end
		end
	end

	// file memory: core write has priority over the side port
	always_ff @(posedge mclk)
	begin
		if (to_file)
			mem[faddr] <= result_reg; // RQ4
		else if (ext_wr_en)
			mem[ext_addr] <= ext_wdata;
		erd_reg <= mem[ext_addr];
	end

	// indirect pointers, one per select value 0 to 2
	genvar gi;
	generate
		for (gi = 0; gi < cor_pkg::PTR_COUNT; gi++)
		begin : g_ptr
			wire logic hit = sel_reg == 2'(gi);
			always_ff @(posedge mclk)
			begin
				if (rst)
					ptr_reg[gi] <= cor_pkg::PTR_RST;
				else if (at_write && hit
					&& (op_reg == cor_pkg::OP_PTR_HI))
					ptr_reg[gi] <= {opd_reg[3:0], 8'h00}; // RQ9 RQ7
				else if (at_write && hit
					&& (op_reg == cor_pkg::OP_PTR_LO))
					ptr_reg[gi][7:0] <= opd_reg; // RQ9
			end
			assign ptr_flat[gi*cor_pkg::PTR_W +: cor_pkg::PTR_W] =
				ptr_reg[gi];
		end
	endgenerate

	// outputs straight from flops
	assign accumulator   = acc_reg;
	assign neg_flag      = neg_reg;
	assign zero_flag     = zero_reg;
	assign quarter_phase = phase_reg;
	assign nop_cycle     = nop_reg;
	assign ext_rdata     = erd_reg;

endmodule : cor_exec
`default_nettype wire

// ---- verification/cor_exec_chk.sv ----
// assertion checker for the or and pointer-load slice
`timescale 1ns/1ps
`default_nettype none
module cor_exec_chk
(
	// clock and reset
	input wire logic                mclk,
	input wire logic                rst,
	// fetch
	input wire logic [15:0]         instr_word,
	input wire logic                instr_valid,
	// core state
	input wire logic [7:0]          accumulator,
	input wire logic                neg_flag,
	input wire logic                zero_flag,
	input wire logic [35:0]         ptr_flat,
	input wire cor_pkg::cor_phase_t quarter_phase,
	input wire logic                nop_cycle
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// word classes at a decode edge
	wire tk = quarter_phase == cor_pkg::Q_DECODE && instr_valid;
	wire lit = tk && instr_word[15:8] == 8'h09;
	wire fil = tk && instr_word[15:10] == 6'h04;
	wire ptr = tk && instr_word[15:6] == 10'h3b8;
	logic prev_ptr_reg;
	// a word after a pointer first word is not an ordinary op
	always_ff @(posedge mclk)
	begin
		if (rst) prev_ptr_reg <= 1'b0;
		else if (tk) prev_ptr_reg <= ptr;
	end
	a_phase_seq: assert property (quarter_phase == cor_pkg::Q_DECODE
		|=> quarter_phase == cor_pkg::Q_READ ##1 quarter_phase ==
		cor_pkg::Q_PROCESS ##1 quarter_phase == cor_pkg::Q_WRITE)
		else $error("phase order wrong");
	a_lit_acc: assert property (lit && !prev_ptr_reg ##1 !nop_cycle
		|-> ##3 accumulator == ($past(accumulator, 4) |
		$past(instr_word[7:0], 4))) else $error("literal or wrong");
	a_lit_flags: assert property (lit && !prev_ptr_reg ##1 !nop_cycle
		|-> ##3 neg_flag == accumulator[7] &&
		zero_flag == (accumulator == 8'h00)) else $error("flags wrong");
	a_ptr_flags: assert property (ptr |=>
		($stable(neg_flag) && $stable(zero_flag)) [*4])
		else $error("pointer load moved flags");
	a_ptr_high: assert property (ptr && !prev_ptr_reg &&
		instr_word[5:4] == 2'h0 ##1 !nop_cycle |-> ##3
		ptr_flat[11:0] == {$past(instr_word[3:0], 4), 8'h00})
		else $error("pointer high write wrong");
	a_sel_none: assert property (ptr && instr_word[5:4] == 2'h3
		|=> $stable(ptr_flat) [*4]) else $error("select 3 wrote");
	a_file_keep: assert property (fil && instr_word[9]
		|=> $stable(accumulator) [*4]) else $error("file target hit acc");
	a_nop_len: assert property ($rose(nop_cycle) |-> nop_cycle [*4])
		else $error("nop cycle too short");
	a_nop_hold: assert property (nop_cycle |-> $stable(accumulator) &&
		$stable(ptr_flat)) else $error("discarded word executed");
	// main scenarios
	c_lit: cover property (lit);
	c_ptr: cover property (ptr);
	c_skip: cover property ($rose(nop_cycle));
endmodule : cor_exec_chk
bind cor_exec cor_exec_chk u_chk (.mclk(mclk), .rst(rst),
	.instr_word(instr_word), .instr_valid(instr_valid),
	.accumulator(accumulator), .neg_flag(neg_flag), .zero_flag(zero_flag),
	.ptr_flat(ptr_flat), .quarter_phase(quarter_phase), .nop_cycle(nop_cycle));
`default_nettype wire

// ---- verification/cor_fetch_model.sv ----
// instruction fetch model, one word per decode edge
`timescale 1ns/1ps
`default_nettype none
module cor_fetch_model
(
	// clock and core phase
	input  wire logic                mclk,
	input  wire cor_pkg::cor_phase_t quarter_phase,
	// fetched word
	output logic [15:0]              instr_word,
	output logic                     instr_valid
);
	// idle at start
	initial
	begin
		instr_word = 16'h5a5a;
		instr_valid = 1'b0;
	end
	// offer a word for the next decode edge
	task automatic put(input logic [15:0] w);
		instr_word = w;
		instr_valid = 1'b1;
	endtask : put
	// withdraw once taken; idle bus shows the inverse, not the old word
	always @(posedge mclk)
	begin
		if (instr_valid && quarter_phase == cor_pkg::Q_DECODE)
		begin
			#1;
			instr_valid = 1'b0;
			instr_word = ~instr_word;
		end
	end
endmodule : cor_fetch_model
`default_nettype wire

// ---- verification/testbench.sv ----
// self-checking bench for the or and pointer-load slice
`timescale 1ns/1ps
`default_nettype none
module testbench;
	// inputs
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic [3:0]  bank_pointer_reg = 4'h0;
	logic        ext_wr_en = 1'b0;
	logic [11:0] ext_addr = 12'h000;
	logic [7:0]  ext_wdata = 8'h00;
	// outputs
	wire logic [15:0] instr_word;
	wire logic instr_valid, neg_flag, zero_flag, nop_cycle;
	wire logic [7:0] ext_rdata, accumulator;
	wire logic [35:0] ptr_flat;
	wire cor_pkg::cor_phase_t quarter_phase;
	// reference state
	int errors = 0, tests_run = 0, seed = 32'h4c99;
	int acc = 0, nf = 0, zf = 0, skip = 0, pend = -1, i, a, b;
	int ptr [3] = '{0, 0, 0};
	int mem [4096];
	always #2.5 mclk = ~mclk;
	cor_exec u_dut (.mclk(mclk), .rst(rst), .instr_word(instr_word),
		.instr_valid(instr_valid), .bank_pointer_reg(bank_pointer_reg),
		.ext_wr_en(ext_wr_en), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
		.ext_rdata(ext_rdata), .accumulator(accumulator),
		.neg_flag(neg_flag), .zero_flag(zero_flag), .ptr_flat(ptr_flat),
		.quarter_phase(quarter_phase), .nop_cycle(nop_cycle));
	cor_fetch_model u_fetch (.mclk(mclk), .quarter_phase(quarter_phase),
		.instr_word(instr_word), .instr_valid(instr_valid));
	// count a comparison, report a mismatch
	task automatic cmp(input logic [35:0] got, exp, input string m);
		tests_run++;
		if (got !== exp)
		begin
			errors++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask : cmp
	// side-port access padded to one instruction cycle
	task automatic side(input int ad, input int d, input logic wr);
		ext_addr = ad[11:0];
		ext_wdata = d[7:0];
		ext_wr_en = wr;
		if (wr) mem[ad] = d & 255;
		@(posedge mclk);
		#1;
		ext_wr_en = 1'b0;
		if (!wr) cmp(ext_rdata, mem[ad][7:0], "file");
		repeat (3) @(posedge mclk);
		#1;
	endtask : side
	// run one word through reference and design, compare after write edge
	task automatic step(input logic [15:0] w);
		int r, ad, drop;
		drop = skip;
		skip = 0;
		ad = (w[8] ? bank_pointer_reg : 4'h0) * 256 + w[7:0];
		r = w[15:10] == 6'h04 ? acc | mem[ad] : (mem[ad] + 1) % 256;
		if (w[15:8] == 8'h09) r = acc | w[7:0];
		if (drop != 0) skip = drop == 1 && w[15:6] == 10'h3b8 ? 2 : 0;
		else if (pend >= 0)
		begin
			if (w[15:8] == 8'hf0 && pend < 3) ptr[pend] += w[7:0];
			pend = -1;
		end
		else if (w[15:8] == 8'h09 || w[15:10] == 6'h04)
		begin
			if (w[15:8] != 8'h09 && w[9]) mem[ad] = r;
			else acc = r;
			nf = r / 128;
			zf = r == 0;
		end
		else if (w[15:10] == 6'h0f || w[15:10] == 6'h12)
		begin
			if (w[9]) mem[ad] = r;
			else acc = r;
			skip = (r == 0) == (w[15:10] == 6'h0f);
		end
		else if (w[15:6] == 10'h3b8)
		begin
			pend = w[5:4];
			if (pend < 3) ptr[pend] = w[3:0] * 256;
		end
		u_fetch.put(w);
		repeat (4) @(posedge mclk);
		#1;
		cmp({accumulator, neg_flag, zero_flag}, {acc[7:0], nf[0], zf[0]}, "core");
		cmp(ptr_flat, {ptr[2][11:0], ptr[1][11:0], ptr[0][11:0]}, "ptr");
		cmp(nop_cycle, drop != 0, "nop");
		cmp(quarter_phase, cor_pkg::Q_DECODE, "phase");
	endtask : step
	// print counts and verdict, end the run
	task automatic close_out;
		$display("compared %0d, mismatched %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : close_out
	// main sequence
	initial
	begin
		repeat (3) @(posedge mclk);
		#1;
		rst = 1'b0;
		step(16'h0900);
		step(16'h099a);
		step(16'h0935);
		for (i = 0; i < 5; i++) step({8'h09, 8'($random(seed) & 127)});
		$display("literal test done");
		for (i = 0; i < 8; i++)
		begin
			a = $random(seed) & 255;
			bank_pointer_reg = 4'($random(seed));
			side(a, $random(seed) & 8'h7e, 1'b1);
			step({8'h3c, a[7:0]});
			b = i[1] ? bank_pointer_reg * 256 + a : a;
			side(b, $random(seed), 1'b1);
			step({6'h04, i[0], i[1], a[7:0]});
			side(b, 0, 1'b0);
		end
		$display("file test done");
		for (i = 0; i < 4; i++)
		begin
			a = $random(seed) & 12'hfff;
			step({8'hee, 2'h0, i[1:0], a[11:8]});
			step({8'hf0, a[7:0]});
		end
		step(16'hee15);
		step(16'hf100);
		$display("pointer test done");
		for (i = 0; i < 2; i++)
		begin
			side(12'h040, 8'hff, 1'b1);
			step(16'h3e40);
			step(i ? 16'hee2c : 16'h0955);
			if (i) step(16'hf077);
			step(16'h4a40);
			step(16'h0901);
			side(12'h040, 0, 1'b0);
		end
		$display("skip test done");
		close_out();
	end
endmodule : testbench
`default_nettype wire
